// *** opto_ctrl_model.sv ***
/*
 controller model that drives the opto command pins of the stepper block.
 assumes the block samples the pins on the rising edge of sys_clk.
*/
`timescale 1ns/1ps
module opto_ctrl_model (
    input wire logic sys_clk,
    output logic [10:0] pins
);
    initial pins = 11'h000;
    // ===============================
    // pin sequencing
    // each change is held 5 edges, longer than the block's 3-edge sync path
    task automatic drive(input logic [10:0] m, input logic v);
        @(posedge sys_clk);
        pins <= v ? (pins | m) : (pins & ~m);
        repeat (4) @(posedge sys_clk);
    endtask : drive
    // the other pulse pin is never touched here, so it keeps its current level
    task automatic pulse(input logic [10:0] m);
        drive(m, 1'b1);
        drive(m, 1'b0);
    endtask : pulse
endmodule : opto_ctrl_model

// *** stepper_driver_input_control.sv ***
/*
 * input command logic of a stepping motor driver: pulse decoding,
 * excitation and shaft release, resolution select, electrical home,
 * deviation clear and alarm reset, with an APB register slave.
 * assumes opto inputs are asynchronous levels (high = current flows) and
 * that fault and step acknowledge inputs come from logic on sys_clk.
 */
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps

// Behaviour
// R1: excitation input high energises the windings; normally open logic.
// R2: single-pulse mode, step rise with direction high gives one cw step.
// R3: single-pulse mode, step rise with direction low gives one ccw step.
// R4: dual-pulse mode, each pulse input rise gives one step its way.
// R5: dual-pulse mode, both inputs high together count no step.
// R6: controller keeps the idle pulse input low while pulsing the other.
// R7: release high cuts current and frees a drive-controlled brake.
// R8: release low restores current and holding torque.
// R9: shaft released on release; held by excitation or brake otherwise.
// R10: separately powered brake ignores the release input.
// R11: push mode remaps select, return and preset pins to push controls.
// R12: switches A,B off: resolution 1000 or 10000 by select input.
// R13: switch A off, B on: resolution 500 or 5000 by select input.
// R14: switch A on ignores select and keeps the second setting.
// R15: select rise with warning enabled warns and blocks home return.
// R16: push current select high switches to the push current.
// R17: home return rise steps the motor back to position zero.
// R18: preset rise zeroes position; controller presets only at standstill.
// R19: deviation clear high zeroes the deviation and ignores pulses.
// R20: deviation clear rise aborts any return operation in progress.
// R21: during an alarm the clear pin falling edge resets soft alarms.
// R22: hard alarms survive alarm reset until power is cycled.
// R23: every input is on when its photocoupler carries current.
// R24: alarm output restored well within 5 ms of the falling edge.
// R25: inputs pass two flip-flops and edges use the synchronised level.
module stepper_driver_input_control (
    input wire logic sys_clk,
    input wire logic srst,
    input wire stepper_pkg::apb_req_t apb_req,
    output stepper_pkg::apb_rsp_t apb_rsp,
    input wire logic excite_cmd,
    input wire logic step_pulse,
    input wire logic dir_or_counterclockwise_step,
    input wire logic shaft_release,
    input wire logic res_select,
    input wire logic home_return,
    input wire logic home_preset,
    input wire logic push_level_bit0,
    input wire logic deviation_clear,
    input wire logic res_switch_a,
    input wire logic res_switch_b,
    input wire logic motor_step_ack,
    input wire logic fault_soft_in,
    input wire logic fault_hard_in,
    output stepper_pkg::motor_cmd_t motor_cmd,
    output logic fault_ok_out,
    output logic warning_out
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [stepper_pkg::NUM_PINS-1:0] s1;
        logic [stepper_pkg::NUM_PINS-1:0] s2;
        logic [stepper_pkg::NUM_PINS-1:0] s3;
        logic [stepper_pkg::CTRL_WIDTH-1:0] ctrl;
        logic signed [31:0] pos;
        logic [15:0] deviation;
        logic soft_alarm;
        logic hard_alarm;
        logic warning;
        logic home_blocked;
        logic preset_seen;
        stepper_pkg::ret_state_t ret;
        logic [15:0] ret_cnt;
        stepper_pkg::motor_cmd_t motor;
        logic fault_ok;
        stepper_pkg::apb_rsp_t rsp;
    } state_t;

    localparam state_t ST_RESET = '{
        s1: '0, s2: '0, s3: '0,
        ctrl: stepper_pkg::CTRL_RESET,
        pos: 32'sh0000_0000,
        deviation: 16'h0000,
        soft_alarm: 1'b0, hard_alarm: 1'b0,
        warning: 1'b0, home_blocked: 1'b0, preset_seen: 1'b0,
        ret: stepper_pkg::RET_IDLE,
        ret_cnt: 16'h0000,
        motor: '0,
        fault_ok: 1'b1,
        rsp: '0
    };

    state_t st_reg;
    state_t st_next;

    logic [stepper_pkg::NUM_PINS-1:0] pins;
    logic [stepper_pkg::NUM_PINS-1:0] lvl;
    logic [stepper_pkg::NUM_PINS-1:0] rise;
    logic [stepper_pkg::NUM_PINS-1:0] fall;
    logic dual_mode;
    logic push_mode;
    logic alarm;
    logic clr_active;
    logic current_on;
    logic accept;
    logic cw_cmd;
    logic ccw_cmd;
    logic step_cw;
    logic step_ccw;
    logic warn_set;
    logic ret_go;
    logic brake_rel;
    logic setup;
    logic wr_done;

    // ==========================================================
    // functions
    function automatic logic [15:0] res_pick(input logic sw_a,
                                             input logic sw_b,
                                             input logic sel);
        logic second;
        second = sw_a | sel; // R14
        if (sw_b) begin
            res_pick = second ? stepper_pkg::RES_TWO_B_ON
                              : stepper_pkg::RES_ONE_B_ON; // R13
        end else begin
            res_pick = second ? stepper_pkg::RES_TWO_B_OFF
                              : stepper_pkg::RES_ONE_B_OFF; // R12
        end
    endfunction : res_pick

    function automatic logic reg_hit(input logic [31:0] addr);
        reg_hit = (addr == stepper_pkg::OFF_CTRL) ||
                  (addr == stepper_pkg::OFF_STATUS) ||
                  (addr == stepper_pkg::OFF_POSITION) ||
                  (addr == stepper_pkg::OFF_DEVIATION) ||
                  (addr == stepper_pkg::OFF_RESOLUTION);
    endfunction : reg_hit

    // ==========================================================
    // next state
    assign pins = {res_switch_b, res_switch_a, deviation_clear,
                   push_level_bit0, home_preset, home_return, res_select,
                   shaft_release, dir_or_counterclockwise_step, step_pulse,
                   excite_cmd};

    always_comb begin
        st_next = st_reg;
        // two-stage synchroniser, then one more stage for edges
        st_next.s1 = pins; // R25 R23
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        lvl = st_reg.s2;
        rise = st_reg.s2 & ~st_reg.s3; // R25
        fall = ~st_reg.s2 & st_reg.s3;

        dual_mode = st_reg.ctrl[stepper_pkg::CTRL_DUAL];
        push_mode = st_reg.ctrl[stepper_pkg::CTRL_THRUST];
        alarm = st_reg.soft_alarm | st_reg.hard_alarm;
        // the shared pin clears deviation only while no alarm is present
        clr_active = lvl[stepper_pkg::PIN_CLEAR] & ~alarm;

        current_on = lvl[stepper_pkg::PIN_EXCITE] &
                     ~lvl[stepper_pkg::PIN_RELEASE] & ~alarm; // R1 R7 R8
        accept = current_on & ~clr_active &
                 (st_reg.ret == stepper_pkg::RET_IDLE); // R19

        if (dual_mode) begin
            // a rise while the other input is high counts nothing
            cw_cmd = rise[stepper_pkg::PIN_STEP] &
                     ~lvl[stepper_pkg::PIN_DIR]; // R4 R5 R6
            ccw_cmd = rise[stepper_pkg::PIN_DIR] &
                      ~lvl[stepper_pkg::PIN_STEP]; // R4 R5 R6
        end else begin
            cw_cmd = rise[stepper_pkg::PIN_STEP] &
                     lvl[stepper_pkg::PIN_DIR]; // R2
            ccw_cmd = rise[stepper_pkg::PIN_STEP] &
                      ~lvl[stepper_pkg::PIN_DIR]; // R3
        end
        step_cw = cw_cmd & accept;
        step_ccw = ccw_cmd & accept;

        // home return lock after a resolution change
        warn_set = rise[stepper_pkg::PIN_RES_SEL] & ~push_mode &
                   ~lvl[stepper_pkg::PIN_SW_A] &
                   st_reg.ctrl[stepper_pkg::CTRL_WARN_EN]; // R15
        ret_go = rise[stepper_pkg::PIN_RETURN] & ~push_mode & current_on &
                 ~clr_active & ~warn_set &
                 (~st_reg.home_blocked | st_reg.preset_seen); // R15 R17
        if (ret_go) begin
            st_next.home_blocked = 1'b0;
            st_next.warning = 1'b0;
            st_next.preset_seen = 1'b0;
        end
        if (rise[stepper_pkg::PIN_PRESET] & ~push_mode &
            st_reg.home_blocked) begin
            st_next.preset_seen = 1'b1;
        end
        if (warn_set) begin
            // a new warning wins over an unlock in the same cycle
            st_next.warning = 1'b1; // R15
            st_next.home_blocked = 1'b1;
            st_next.preset_seen = 1'b0;
        end

        // return to electrical home
        case (st_reg.ret)
            stepper_pkg::RET_IDLE: begin
                if (ret_go) begin
                    st_next.ret = stepper_pkg::RET_RUN; // R17
                    st_next.ret_cnt = stepper_pkg::RET_RELOAD;
                end
            end
            stepper_pkg::RET_RUN: begin
                if ((rise[stepper_pkg::PIN_CLEAR] & ~alarm) | warn_set |
                    ~current_on | (st_reg.pos == 32'sh0000_0000)) begin
                    st_next.ret = stepper_pkg::RET_IDLE; // R20 R17 R15
                end else if (st_reg.ret_cnt == 16'h0000) begin
                    st_next.ret_cnt = stepper_pkg::RET_RELOAD;
                    step_cw = st_reg.pos < 32'sh0000_0000; // R17
                    step_ccw = st_reg.pos > 32'sh0000_0000;
                end else begin
                    st_next.ret_cnt = st_reg.ret_cnt - 16'h0001;
                end
            end
            default: begin
                st_next.ret = stepper_pkg::RET_IDLE;
            end
        endcase

        // accumulated command position; preset has priority
        if (rise[stepper_pkg::PIN_PRESET] & ~push_mode) begin
            st_next.pos = 32'sh0000_0000; // R18
        end else if (step_cw) begin
            st_next.pos = st_reg.pos + 32'sh0000_0001;
        end else if (step_ccw) begin
            st_next.pos = st_reg.pos - 32'sh0000_0001;
        end

        // deviation: steps issued but not yet taken by the motor stage
        if (clr_active) begin
            st_next.deviation = 16'h0000; // R19
        end else if ((step_cw | step_ccw) & ~motor_step_ack) begin
            if (st_reg.deviation != 16'hffff) begin
                st_next.deviation = st_reg.deviation + 16'h0001;
            end
        end else if (~(step_cw | step_ccw) & motor_step_ack) begin
            if (st_reg.deviation != 16'h0000) begin
                st_next.deviation = st_reg.deviation - 16'h0001;
            end
        end

        // alarms: a new fault wins over a reset edge
        if (alarm & fall[stepper_pkg::PIN_CLEAR]) begin
            st_next.soft_alarm = 1'b0; // R21
        end
        if (fault_soft_in) begin
            st_next.soft_alarm = 1'b1;
        end
        if (fault_hard_in) begin
            st_next.hard_alarm = 1'b1; // R22
        end
        st_next.fault_ok = ~(st_next.soft_alarm | st_next.hard_alarm); // R24

        // brake released by excitation or the release input; an alarm leaves it holding
        brake_rel = st_reg.ctrl[stepper_pkg::CTRL_BRAKE_DRIVE] &
                    ~st_reg.ctrl[stepper_pkg::CTRL_BRAKE_SEP] & ~alarm &
                    (lvl[stepper_pkg::PIN_RELEASE] | current_on); // R9 R10

        st_next.motor.current_on = current_on; // R9
        st_next.motor.brake_release = brake_rel; // R7
        st_next.motor.step_cw = step_cw;
        st_next.motor.step_ccw = step_ccw;
        st_next.motor.push_current = push_mode &
                                     lvl[stepper_pkg::PIN_RES_SEL]; // R16
        st_next.motor.push_level = push_mode ?
            {lvl[stepper_pkg::PIN_PRESET], lvl[stepper_pkg::PIN_RETURN],
             lvl[stepper_pkg::PIN_LEVEL0]} : 3'h0; // R11
        st_next.motor.resolution = res_pick(lvl[stepper_pkg::PIN_SW_A],
            lvl[stepper_pkg::PIN_SW_B],
            ~push_mode & lvl[stepper_pkg::PIN_RES_SEL]); // R11

        // APB: read data captured in setup, ready in the access cycle
        setup = apb_req.psel & ~apb_req.penable;
        wr_done = apb_req.psel & apb_req.penable & st_reg.rsp.pready &
                  apb_req.pwrite;
        st_next.rsp.pready = setup;
        st_next.rsp.pslverr = setup & ~reg_hit(apb_req.paddr);
        st_next.rsp.prdata = 32'h0000_0000;
        if (setup & ~apb_req.pwrite) begin
            case (apb_req.paddr)
                stepper_pkg::OFF_CTRL: begin
                    st_next.rsp.prdata = {27'h0000000, st_reg.ctrl};
                end
                stepper_pkg::OFF_STATUS: begin
                    st_next.rsp.prdata = {22'h000000,
                        st_reg.preset_seen, st_reg.motor.push_current,
                        st_reg.hard_alarm, st_reg.soft_alarm,
                        st_reg.ret == stepper_pkg::RET_RUN,
                        st_reg.home_blocked, st_reg.warning,
                        st_reg.ctrl[stepper_pkg::CTRL_BRAKE_DRIVE] &
                            ~st_reg.ctrl[stepper_pkg::CTRL_BRAKE_SEP] &
                            ~st_reg.motor.brake_release,
                        ~st_reg.motor.current_on &
                            (st_reg.motor.brake_release |
                             ~st_reg.ctrl[stepper_pkg::CTRL_BRAKE_DRIVE] |
                             st_reg.ctrl[stepper_pkg::CTRL_BRAKE_SEP]),
                        st_reg.motor.current_on};
                end
                stepper_pkg::OFF_POSITION: begin
                    st_next.rsp.prdata = st_reg.pos;
                end
                stepper_pkg::OFF_DEVIATION: begin
                    st_next.rsp.prdata = {16'h0000, st_reg.deviation};
                end
                stepper_pkg::OFF_RESOLUTION: begin
                    st_next.rsp.prdata = {16'h0000, st_reg.motor.resolution};
                end
                default: begin
                    st_next.rsp.prdata = 32'h0000_0000;
                end
            endcase
        end
        if (wr_done & (apb_req.paddr == stepper_pkg::OFF_CTRL)) begin
            st_next.ctrl = apb_req.pwdata[stepper_pkg::CTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_rsp = st_reg.rsp;
    assign motor_cmd = st_reg.motor;
    assign fault_ok_out = st_reg.fault_ok;
    assign warning_out = st_reg.warning;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_single_cw_step: assert property ( // R2
        !dual_mode && rise[stepper_pkg::PIN_STEP] &&
        lvl[stepper_pkg::PIN_DIR] && accept |=> motor_cmd.step_cw)
        else $error("cw step missing in single-pulse mode");
    a_single_ccw_step: assert property ( // R3
        !dual_mode && rise[stepper_pkg::PIN_STEP] &&
        !lvl[stepper_pkg::PIN_DIR] && accept
        |=> motor_cmd.step_ccw && !motor_cmd.step_cw)
        else $error("ccw step missing in single-pulse mode");
    a_dual_both_high: assert property ( // R5
        dual_mode && lvl[stepper_pkg::PIN_STEP] &&
        lvl[stepper_pkg::PIN_DIR] && st_reg.ret == stepper_pkg::RET_IDLE
        |=> !motor_cmd.step_cw && !motor_cmd.step_ccw)
        else $error("step counted with both pulse inputs on");
    a_release_cuts_current: assert property ( // R7
        lvl[stepper_pkg::PIN_RELEASE]
        |=> !motor_cmd.current_on)
        else $error("current on while release is on");
    a_excite_holds: assert property ( // R1
        lvl[stepper_pkg::PIN_EXCITE] && !lvl[stepper_pkg::PIN_RELEASE] &&
        !alarm |=> motor_cmd.current_on)
        else $error("no excitation with excite on");
    a_clear_blocks_pulses: assert property ( // R19
        clr_active && st_reg.ret == stepper_pkg::RET_IDLE
        |=> !motor_cmd.step_cw && !motor_cmd.step_ccw &&
            st_reg.deviation == 16'h0000)
        else $error("pulses accepted during deviation clear");
    a_clear_aborts_return: assert property ( // R20
        st_reg.ret == stepper_pkg::RET_RUN &&
        rise[stepper_pkg::PIN_CLEAR] && !alarm
        |=> st_reg.ret == stepper_pkg::RET_IDLE)
        else $error("return not aborted by deviation clear");
    a_alarm_reset_fall: assert property ( // R21
        st_reg.soft_alarm && !st_reg.hard_alarm &&
        fall[stepper_pkg::PIN_CLEAR] && !fault_soft_in && !fault_hard_in
        |=> fault_ok_out)
        else $error("alarm not reset on falling edge");
    a_hard_alarm_stays: assert property ( // R22
        st_reg.hard_alarm |=> !fault_ok_out ##1 !fault_ok_out)
        else $error("hard alarm cleared");
    a_warn_blocks_home: assert property ( // R15
        warn_set |=> warning_out && st_reg.home_blocked
        && st_reg.ret == stepper_pkg::RET_IDLE)
        else $error("warning did not block home return");
    a_preset_zeroes: assert property ( // R18
        rise[stepper_pkg::PIN_PRESET] && !push_mode
        |=> st_reg.pos == 32'sh0000_0000)
        else $error("preset did not zero position");
    a_switch_a_second: assert property ( // R14
        lvl[stepper_pkg::PIN_SW_A] && !lvl[stepper_pkg::PIN_SW_B]
        |=> motor_cmd.resolution == stepper_pkg::RES_TWO_B_OFF)
        else $error("switch a did not force second resolution");
    a_push_current_sel: assert property ( // R16
        push_mode && lvl[stepper_pkg::PIN_RES_SEL]
        |=> motor_cmd.push_current && motor_cmd.resolution ==
            $past(res_pick(lvl[stepper_pkg::PIN_SW_A],
                  lvl[stepper_pkg::PIN_SW_B], 1'b0)))
        else $error("push current not selected");
    a_apb_one_wait: assert property (
        setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("apb ready timing wrong");

endmodule : stepper_driver_input_control

// *** stepper_pkg.sv ***
/*
 * constants, field layouts and carrier types for the stepper input control
 * block. assumes a 100 MHz sys_clk and an APB master with 32-bit data.
 */
package stepper_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    // interval between two steps of a return to electrical home
    localparam int unsigned RET_STEP_TIME_NS = 10000;
    localparam int unsigned RET_STEP_CYCLES =
        (RET_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] RET_RELOAD = 16'(RET_STEP_CYCLES - 1);

    // ==========================================================
    // register byte offsets
    localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFF_STATUS = 32'h0000_0004;
    localparam logic [31:0] OFF_POSITION = 32'h0000_0008;
    localparam logic [31:0] OFF_DEVIATION = 32'h0000_000c;
    localparam logic [31:0] OFF_RESOLUTION = 32'h0000_0010;

    // ==========================================================
    // control register fields
    localparam int CTRL_WIDTH = 5;
    localparam int CTRL_DUAL = 0;
    localparam int CTRL_THRUST = 1;
    localparam int CTRL_BRAKE_DRIVE = 2;
    localparam int CTRL_BRAKE_SEP = 3;
    localparam int CTRL_WARN_EN = 4;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;

    // status register fields
    localparam int ST_CURRENT = 0;
    localparam int ST_RELEASED = 1;
    localparam int ST_BRAKE_HOLD = 2;
    localparam int ST_WARNING = 3;
    localparam int ST_BLOCKED = 4;
    localparam int ST_RETURNING = 5;
    localparam int ST_SOFT_ALARM = 6;
    localparam int ST_HARD_ALARM = 7;
    localparam int ST_PUSH_CUR = 8;
    localparam int ST_PRESET_SEEN = 9;

    // ==========================================================
    // resolution defaults in pulses per revolution
    localparam logic [15:0] RES_ONE_B_OFF = 16'h03e8;
    localparam logic [15:0] RES_TWO_B_OFF = 16'h2710;
    localparam logic [15:0] RES_ONE_B_ON = 16'h01f4;
    localparam logic [15:0] RES_TWO_B_ON = 16'h1388;

    // ==========================================================
    // opto input vector positions
    localparam int NUM_PINS = 11;
    localparam int PIN_EXCITE = 0;
    localparam int PIN_STEP = 1;
    localparam int PIN_DIR = 2;
    localparam int PIN_RELEASE = 3;
    localparam int PIN_RES_SEL = 4;
    localparam int PIN_RETURN = 5;
    localparam int PIN_PRESET = 6;
    localparam int PIN_LEVEL0 = 7;
    localparam int PIN_CLEAR = 8;
    localparam int PIN_SW_A = 9;
    localparam int PIN_SW_B = 10;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic current_on;
        logic brake_release;
        logic step_cw;
        logic step_ccw;
        logic push_current;
        logic [2:0] push_level;
        logic [15:0] resolution;
    } motor_cmd_t;

    typedef enum logic [0:0] {RET_IDLE, RET_RUN} ret_state_t;

endpackage : stepper_pkg

// *** tb_stepper_driver_input_control.sv ***
/*
 self-checking bench for the stepper input control block.
 assumes the opto controller model and an APB slave with one-cycle answer.
*/
`timescale 1ns/1ps
module tb_stepper_driver_input_control;
    logic sys_clk, srst, f_soft, f_hard, erb;
    stepper_pkg::apb_req_t req;
    stepper_pkg::apb_rsp_t rsp;
    stepper_pkg::motor_cmd_t cmd;
    logic ok, warn;
    logic [10:0] p;
    logic [31:0] rd;
    logic [15:0] e;
    int n_fail, checks_done, n_cw, n_ccw;
    opto_ctrl_model ctl (.sys_clk(sys_clk), .pins(p));
    stepper_driver_input_control dut (.sys_clk(sys_clk), .srst(srst),
        .apb_req(req), .apb_rsp(rsp), .excite_cmd(p[0]), .step_pulse(p[1]),
        .dir_or_counterclockwise_step(p[2]), .shaft_release(p[3]),
        .res_select(p[4]), .home_return(p[5]), .home_preset(p[6]),
        .push_level_bit0(p[7]), .deviation_clear(p[8]),
        .res_switch_a(p[9]), .res_switch_b(p[10]),
        .motor_step_ack(cmd.step_cw),
        .fault_soft_in(f_soft), .fault_hard_in(f_hard), .motor_cmd(cmd),
        .fault_ok_out(ok), .warning_out(warn));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (cmd.step_cw === 1'b1) n_cw++;
        if (cmd.step_ccw === 1'b1) n_ccw++;
    end
    // ===============================
    // shared tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string s, input logic [31:0] x,
                       input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (rsp.pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            end_sim();
        end
        rd = rsp.prdata;
        erb = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic fault(input logic hard);
        @(posedge sys_clk);
        if (hard) f_hard <= 1'b1;
        else f_soft <= 1'b1;
        @(posedge sys_clk);
        f_soft <= 1'b0;
        f_hard <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : fault
    // ===============================
    // scenarios
    task automatic t_excite();
        ctl.drive(11'h001, 1'b1);
        chk("current_on", 1, cmd.current_on);
        apb(1'b1, stepper_pkg::OFF_CTRL, 32'h4);
        ctl.drive(11'h008, 1'b1);
        chk("current_on", 0, cmd.current_on);
        chk("brake_release", 1, cmd.brake_release);
        ctl.drive(11'h008, 1'b0);
        chk("current_on", 1, cmd.current_on);
        ctl.drive(11'h001, 1'b0);
        chk("brake_release", 0, cmd.brake_release);
        apb(1'b1, stepper_pkg::OFF_CTRL, 32'hc);
        ctl.drive(11'h008, 1'b1);
        chk("brake_release", 0, cmd.brake_release);
        ctl.drive(11'h008, 1'b0);
        ctl.drive(11'h001, 1'b1);
    endtask : t_excite
    task automatic t_single();
        ctl.drive(11'h004, 1'b1);
        ctl.pulse(11'h002);
        ctl.pulse(11'h002);
        ctl.drive(11'h004, 1'b0);
        ctl.pulse(11'h002);
        chk("cw steps", 2, n_cw);
        chk("ccw steps", 1, n_ccw);
        apb(1'b0, stepper_pkg::OFF_POSITION, 0);
        chk("position", 1, rd);
        ctl.pulse(11'h040);
        apb(1'b0, stepper_pkg::OFF_POSITION, 0);
        chk("position", 0, rd);
        ctl.drive(11'h100, 1'b1);
        ctl.pulse(11'h002);
        chk("ccw steps", 1, n_ccw);
        ctl.drive(11'h100, 1'b0);
    endtask : t_single
    task automatic t_dual();
        apb(1'b1, stepper_pkg::OFF_CTRL, 32'h1);
        ctl.pulse(11'h002);
        ctl.pulse(11'h004);
        chk("cw steps", 3, n_cw);
        chk("ccw steps", 2, n_ccw);
        ctl.pulse(11'h006);
        chk("cw+ccw", 5, n_cw + n_ccw);
        apb(1'b1, stepper_pkg::OFF_CTRL, 32'h0);
    endtask : t_dual
    task automatic t_res();
        for (int i = 0; i < 8; i++) begin
            ctl.drive(11'h200, i[2]);
            ctl.drive(11'h400, i[1]);
            ctl.drive(11'h010, i[0]);
            e = (i[0] | i[2]) ? (i[1] ? 16'h1388 : 16'h2710)
                              : (i[1] ? 16'h01f4 : 16'h03e8);
            chk("resolution", e, cmd.resolution);
        end
        ctl.drive(11'h210, 1'b0);
        apb(1'b1, stepper_pkg::OFF_CTRL, 32'h10);
        chk("warning", 0, warn);
        ctl.drive(11'h010, 1'b1);
        chk("warning", 1, warn);
    endtask : t_res
    task automatic t_home();
        ctl.pulse(11'h020);
        chk("warning", 1, warn);
        ctl.pulse(11'h040);
        ctl.pulse(11'h002);
        ctl.pulse(11'h002);
        ctl.pulse(11'h020);
        chk("warning", 0, warn);
        repeat (1000) @(posedge sys_clk);
        ctl.pulse(11'h100);
        repeat (1000) @(posedge sys_clk);
        apb(1'b0, stepper_pkg::OFF_POSITION, 0);
        chk("position", -1, rd);
        apb(1'b0, stepper_pkg::OFF_DEVIATION, 0);
        chk("deviation", 0, rd);
        apb(1'b1, stepper_pkg::OFF_CTRL, 32'h2);
        ctl.drive(11'h0a0, 1'b1);
        chk("push_level", 3, cmd.push_level);
        chk("push_current", 1, cmd.push_current);
    endtask : t_home
    task automatic t_alarm();
        fault(1'b0);
        chk("fault_ok", 0, ok);
        chk("current_on", 0, cmd.current_on);
        ctl.drive(11'h100, 1'b1);
        chk("fault_ok", 0, ok);
        ctl.drive(11'h100, 1'b0);
        chk("fault_ok", 1, ok);
        fault(1'b1);
        ctl.pulse(11'h100);
        chk("fault_ok", 0, ok);
    endtask : t_alarm
    initial begin
        srst = 1'b1;
        req = '0;
        f_soft = 1'b0;
        f_hard = 1'b0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        apb(1'b0, stepper_pkg::OFF_CTRL, 0);
        chk("ctrl reset", 0, rd);
        apb(1'b0, 32'h0000_0020, 0);
        chk("unmapped err", 1, erb);
        t_excite();
        t_single();
        t_dual();
        t_res();
        t_home();
        t_alarm();
        end_sim();
    end
    initial begin
        repeat (50000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end
endmodule : tb_stepper_driver_input_control
